// ### regulator_config_pkg.sv
package regulator_config_pkg;

   localparam logic [7:0] buck_switching_mode_config_addr = 8'h03;
   localparam logic [7:0] ldo4_config_addr = 8'h04;
   localparam logic [7:0] ldo3_config_addr = 8'h05;
   localparam logic [7:0] ldo2_config_addr = 8'h06;
   localparam logic [7:0] ldo1_config_addr = 8'h07;
   localparam logic [7:0] buck3_config_addr = 8'h08;
   localparam logic [7:0] buck2_config_addr = 8'h09;
   localparam logic [7:0] buck1_config_addr = 8'h0a;
   localparam logic [7:0] ldo_uv_threshold_config_addr = 8'h1e;
   localparam logic [7:0] standby_enable_config_addr = 8'h21;

   localparam logic [7:0] buck_switching_mode_reset = 8'h00;
   localparam logic [7:0] ldo_config_reset = 8'h00;
   localparam logic [7:0] buck_config_reset = 8'h00;
   localparam logic [7:0] ldo_uv_threshold_reset = 8'h00;
   localparam logic [7:0] standby_enable_reset = 8'h00;

   localparam int bandwidth_bit = 7;
   localparam int buck_undervolt_bit = 6;
   localparam int voltage_code_msb = 5;
   localparam int spread_spectrum_bit = 5;
   localparam int fixed_frequency_bit = 4;
   localparam int buck_three_phase_lsb = 2;
   localparam int buck_two_phase_lsb = 0;
   localparam int linreg_load_switch_bit = 7;
   localparam int linreg_bypass_bit = 6;
   localparam int linreg_mode_bit = 6;
   localparam int linreg_slow_ramp_bit = 7;
   localparam int linreg_uv_first_bit = 3;
   localparam int standby_buck_one_bit = 0;

   typedef enum logic [1:0] {
      linreg_regulating,
      linreg_bypassing,
      linreg_load_switching
   } linreg_mode_type;

endpackage

// ### serial_write_port.sv
`timescale 1ns/1ps
module serial_write_port
   import regulator_config_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic wr_req_i,
   input wire logic rd_req_i,
   input wire logic [7:0] addr_i,
   output logic wr_pulse_o,
   output logic rd_pulse_o,
   output logic [7:0] addr_o
);

   logic [1:0] wr_sync;
   logic [1:0] rd_sync;
   logic wr_last;
   logic rd_last;
   logic [7:0] addr_meta;

   // Request strobes come from the serial front end and are resynchronised.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_sync <= 2'b00;
         rd_sync <= 2'b00;
         wr_last <= 1'b0;
         rd_last <= 1'b0;
         wr_pulse_o <= 1'b0;
         rd_pulse_o <= 1'b0;
         addr_meta <= 8'h00;
         addr_o <= 8'h00;
      end else begin
         wr_sync <= {wr_sync[0], wr_req_i};
         rd_sync <= {rd_sync[0], rd_req_i};
         wr_last <= wr_sync[1];
         rd_last <= rd_sync[1];
         wr_pulse_o <= wr_sync[1] & ~wr_last;
         rd_pulse_o <= rd_sync[1] & ~rd_last;
         addr_meta <= addr_i;
         addr_o <= addr_meta;
      end
   end

endmodule

// ### regulator_config_register_bank.sv
`timescale 1ns/1ps
// What this block does
// - First buck byte: bit7 bandwidth, bit6 undervolt select, bits5-0 voltage code.
// - Second buck byte uses the same layout as the first.
// - Third buck byte uses the same layout as the first.
// - Buck undervolt select clear means minus 5 percent, set minus 10 percent.
// - Bit 5 of switching-mode register enables spread spectrum.
// - Bits 3-2 phase buck three, bits 1-0 buck two, 90 degree steps.
// - Spread spectrum and phase act only while fixed frequency is set.
// - First linear byte: bits5-0 code, bit7 load switch, bit6 bypass.
// - Load switch wins; else bypass bit picks bypass or regulating.
// - Second linear byte holds code, load switch and bypass.
// - Third linear byte: bits5-0 code, bit6 mode, bit7 ramp select.
// - Fourth linear byte: bits5-0 code, bit6 mode, bit7 ramp select.
// - Ramp select clear means fast ramp, set means slow ramp.
// - Linear undervolt selects in bits 3 to 6 of one shared register.
// - Standby enable register, bit 0 enables the first buck in standby.
module regulator_config_register_bank
   import regulator_config_pkg::*;
#(
   parameter int num_bucks = 3,
   parameter int num_linregs = 4
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic wr_req_i,
   input wire logic rd_req_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic [5:0] buck_one_voltage_code_o,
   output logic [5:0] buck_two_voltage_code_o,
   output logic [5:0] buck_three_voltage_code_o,
   output logic [2:0] bandwidth_high_o,
   output logic [2:0] buck_undervolt_ten_pct_o,
   output logic fixed_frequency_enable_o,
   output logic spread_spectrum_active_o,
   output logic [1:0] buck_two_phase_offset_o,
   output logic [1:0] buck_three_phase_offset_o,
   output logic [5:0] linreg_one_voltage_code_o,
   output logic [5:0] linreg_two_voltage_code_o,
   output logic [5:0] linreg_three_voltage_code_o,
   output logic [5:0] linreg_four_voltage_code_o,
   output logic [1:0] linreg_one_mode_o,
   output logic [1:0] linreg_two_mode_o,
   output logic linreg_three_load_switch_o,
   output logic linreg_four_load_switch_o,
   output logic linreg_three_slow_ramp_o,
   output logic linreg_four_slow_ramp_o,
   output logic [3:0] linreg_undervolt_ten_pct_o,
   output logic buck_one_standby_enable_o
);

   if (num_bucks != 3 || num_linregs != 4) begin : g_size_check
      $error("Only three bucks and four linear regulators are supported.");
   end

   logic wr_pulse;
   logic rd_pulse;
   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] wdata_s;

   logic [7:0] buck_config [3];
   logic [7:0] buck_switching_mode;
   logic [7:0] ldo1_config;
   logic [7:0] ldo2_config;
   logic [7:0] ldo3_config;
   logic [7:0] ldo4_config;
   logic [7:0] ldo_uv_threshold;
   logic [7:0] standby_enable;
   logic [7:0] next_rdata;
   logic [1:0] next_linreg_one_mode;
   logic [1:0] next_linreg_two_mode;

   serial_write_port port_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .wr_req_i(wr_req_i),
      .rd_req_i(rd_req_i),
      .addr_i(addr_i),
      .wr_pulse_o(wr_pulse),
      .rd_pulse_o(rd_pulse),
      .addr_o(addr_q)
   );

   // Data is held stable by the front end; it is staged alongside the strobes.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdata_s <= 8'h00;
         wdata_q <= 8'h00;
      end else begin
         wdata_s <= wdata_i;
         wdata_q <= wdata_s;
      end
   end

   // Buck bytes: index 0 is buck one at 0x0a, down to buck three at 0x08.
   for (genvar b = 0; b < 3; b++) begin : g_buck
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            buck_config[b] <= buck_config_reset;
         end else if (wr_pulse && addr_q == buck1_config_addr - 8'(b)) begin
            buck_config[b] <= wdata_q;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buck_switching_mode <= buck_switching_mode_reset;
      end else if (wr_pulse && addr_q == buck_switching_mode_config_addr) begin
         buck_switching_mode <= wdata_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ldo1_config <= ldo_config_reset;
      end else if (wr_pulse && addr_q == ldo1_config_addr) begin
         ldo1_config <= wdata_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ldo2_config <= ldo_config_reset;
      end else if (wr_pulse && addr_q == ldo2_config_addr) begin
         ldo2_config <= wdata_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ldo3_config <= ldo_config_reset;
      end else if (wr_pulse && addr_q == ldo3_config_addr) begin
         ldo3_config <= wdata_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ldo4_config <= ldo_config_reset;
      end else if (wr_pulse && addr_q == ldo4_config_addr) begin
         ldo4_config <= wdata_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ldo_uv_threshold <= ldo_uv_threshold_reset;
      end else if (wr_pulse && addr_q == ldo_uv_threshold_config_addr) begin
         ldo_uv_threshold <= wdata_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         standby_enable <= standby_enable_reset;
      end else if (wr_pulse && addr_q == standby_enable_config_addr) begin
         standby_enable <= wdata_q;
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      next_rdata = 8'h00;
      case (addr_q)
         buck_switching_mode_config_addr: next_rdata = buck_switching_mode;
         ldo4_config_addr: next_rdata = ldo4_config;
         ldo3_config_addr: next_rdata = ldo3_config;
         ldo2_config_addr: next_rdata = ldo2_config;
         ldo1_config_addr: next_rdata = ldo1_config;
         buck3_config_addr: next_rdata = buck_config[2];
         buck2_config_addr: next_rdata = buck_config[1];
         buck1_config_addr: next_rdata = buck_config[0];
         ldo_uv_threshold_config_addr: next_rdata = ldo_uv_threshold;
         standby_enable_config_addr: next_rdata = standby_enable;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= rd_pulse;
         if (rd_pulse) begin
            rdata_o <= next_rdata;
         end
      end
   end

   // Load switch wins over bypass for the first two linear regulators.
   always_comb begin
      if (ldo1_config[linreg_load_switch_bit]) begin
         next_linreg_one_mode = linreg_load_switching;
      end else if (ldo1_config[linreg_bypass_bit]) begin
         next_linreg_one_mode = linreg_bypassing;
      end else begin
         next_linreg_one_mode = linreg_regulating;
      end
      if (ldo2_config[linreg_load_switch_bit]) begin
         next_linreg_two_mode = linreg_load_switching;
      end else if (ldo2_config[linreg_bypass_bit]) begin
         next_linreg_two_mode = linreg_bypassing;
      end else begin
         next_linreg_two_mode = linreg_regulating;
      end
   end

   // Voltage codes toward the buck power stages, registered.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buck_one_voltage_code_o <= 6'h00;
         buck_two_voltage_code_o <= 6'h00;
         buck_three_voltage_code_o <= 6'h00;
      end else begin
         buck_one_voltage_code_o <= buck_config[0][voltage_code_msb:0];
         buck_two_voltage_code_o <= buck_config[1][voltage_code_msb:0];
         buck_three_voltage_code_o <= buck_config[2][voltage_code_msb:0];
      end
   end

   // Bit 0 of each buck vector is buck one, bit 2 is buck three.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bandwidth_high_o <= 3'h0;
      end else begin
         bandwidth_high_o <= {buck_config[2][bandwidth_bit], buck_config[1][bandwidth_bit],
                              buck_config[0][bandwidth_bit]};
      end
   end

   // A set select bit moves the undervolt detection to minus 10 percent.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buck_undervolt_ten_pct_o <= 3'h0;
      end else begin
         buck_undervolt_ten_pct_o <= {buck_config[2][buck_undervolt_bit],
                                      buck_config[1][buck_undervolt_bit],
                                      buck_config[0][buck_undervolt_bit]};
      end
   end

   // Fixed-frequency switching is passed through as stored.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fixed_frequency_enable_o <= 1'b0;
      end else begin
         fixed_frequency_enable_o <= buck_switching_mode[fixed_frequency_bit];
      end
   end

   // Spread spectrum is forced off outside fixed-frequency switching.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spread_spectrum_active_o <= 1'b0;
      end else if (buck_switching_mode[fixed_frequency_bit]) begin
         spread_spectrum_active_o <= buck_switching_mode[spread_spectrum_bit];
      end else begin
         spread_spectrum_active_o <= 1'b0;
      end
   end

   // Phase offsets fall back to zero degrees outside fixed-frequency switching.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buck_two_phase_offset_o <= 2'h0;
         buck_three_phase_offset_o <= 2'h0;
      end else if (buck_switching_mode[fixed_frequency_bit]) begin
         buck_three_phase_offset_o <=
            buck_switching_mode[buck_three_phase_lsb +: 2];
         buck_two_phase_offset_o <= buck_switching_mode[buck_two_phase_lsb +: 2];
      end else begin
         buck_three_phase_offset_o <= 2'h0;
         buck_two_phase_offset_o <= 2'h0;
      end
   end

   // Voltage codes toward the linear regulators, registered.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         linreg_one_voltage_code_o <= 6'h00;
         linreg_two_voltage_code_o <= 6'h00;
         linreg_three_voltage_code_o <= 6'h00;
         linreg_four_voltage_code_o <= 6'h00;
      end else begin
         linreg_one_voltage_code_o <= ldo1_config[voltage_code_msb:0];
         linreg_two_voltage_code_o <= ldo2_config[voltage_code_msb:0];
         linreg_three_voltage_code_o <= ldo3_config[voltage_code_msb:0];
         linreg_four_voltage_code_o <= ldo4_config[voltage_code_msb:0];
      end
   end

   // Operating mode of the first two linear regulators.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         linreg_one_mode_o <= 2'h0;
         linreg_two_mode_o <= 2'h0;
      end else begin
         linreg_one_mode_o <= next_linreg_one_mode;
         linreg_two_mode_o <= next_linreg_two_mode;
      end
   end

   // A set mode bit of the last two linear regulators selects load-switch operation.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         linreg_three_load_switch_o <= 1'b0;
         linreg_four_load_switch_o <= 1'b0;
      end else begin
         linreg_three_load_switch_o <= ldo3_config[linreg_mode_bit];
         linreg_four_load_switch_o <= ldo4_config[linreg_mode_bit];
      end
   end

   // A set ramp select of the last two linear regulators selects the slow ramp.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         linreg_three_slow_ramp_o <= 1'b0;
         linreg_four_slow_ramp_o <= 1'b0;
      end else begin
         linreg_three_slow_ramp_o <= ldo3_config[linreg_slow_ramp_bit];
         linreg_four_slow_ramp_o <= ldo4_config[linreg_slow_ramp_bit];
      end
   end

   // Undervolt selects of the linear regulators, bit 0 for the first one.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         linreg_undervolt_ten_pct_o <= 4'h0;
      end else begin
         linreg_undervolt_ten_pct_o <= ldo_uv_threshold[linreg_uv_first_bit +: 4];
      end
   end

   // Standby enable of the first buck.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buck_one_standby_enable_o <= 1'b0;
      end else begin
         buck_one_standby_enable_o <= standby_enable[standby_buck_one_bit];
      end
   end

endmodule

// ### regulator_config_asserts.sv
`timescale 1ns/1ps
module regulator_config_asserts
   import regulator_config_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic wr_req_i,
   input wire logic rd_req_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic rvalid_o,
   input wire logic [5:0] buck_one_voltage_code_o,
   input wire logic [2:0] bandwidth_high_o,
   input wire logic [2:0] buck_undervolt_ten_pct_o,
   input wire logic fixed_frequency_enable_o,
   input wire logic spread_spectrum_active_o,
   input wire logic [1:0] buck_two_phase_offset_o,
   input wire logic [1:0] buck_three_phase_offset_o,
   input wire logic [1:0] linreg_one_mode_o,
   input wire logic [5:0] linreg_four_voltage_code_o,
   input wire logic linreg_four_load_switch_o,
   input wire logic linreg_four_slow_ramp_o,
   input wire logic [3:0] linreg_undervolt_ten_pct_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // A write held for seven cycles has reached the decoded outputs.
   sequence held_write(logic [7:0] a);
      (wr_req_i && addr_i == a) [*7];
   endsequence
   rvalid_single_a: assert property (rvalid_o |=> !rvalid_o)
      else $error("read valid longer than one cycle");
   read_answer_a: assert property ($rose(rd_req_i) |-> ##[2:6] rvalid_o)
      else $error("read not answered in time");
   switch_gate_a: assert property (!fixed_frequency_enable_o |-> !spread_spectrum_active_o
      && buck_two_phase_offset_o == 2'h0 && buck_three_phase_offset_o == 2'h0)
      else $error("spread or phase active without fixed frequency");
   switch_write_a: assert property (held_write(buck_switching_mode_config_addr) |->
      spread_spectrum_active_o == (wdata_i[5] & wdata_i[4])
      && buck_three_phase_offset_o == (wdata_i[4] ? wdata_i[3:2] : 2'h0))
      else $error("switching fields wrong after write");
   buck_one_write_a: assert property (held_write(buck1_config_addr) |->
      buck_one_voltage_code_o == wdata_i[5:0] && bandwidth_high_o[0] == wdata_i[7]
      && buck_undervolt_ten_pct_o[0] == wdata_i[6])
      else $error("first buck fields wrong after write");
   linreg_one_mode_a: assert property (held_write(ldo1_config_addr) |->
      linreg_one_mode_o == (wdata_i[7] ? 2'h2 : {1'b0, wdata_i[6]}))
      else $error("first linear mode wrong after write");
   linreg_four_write_a: assert property (held_write(ldo4_config_addr) |->
      linreg_four_voltage_code_o == wdata_i[5:0] && linreg_four_load_switch_o == wdata_i[6]
      && linreg_four_slow_ramp_o == wdata_i[7])
      else $error("fourth linear fields wrong after write");
   linreg_uv_write_a: assert property (held_write(ldo_uv_threshold_config_addr) |->
      linreg_undervolt_ten_pct_o == wdata_i[6:3])
      else $error("linear thresholds wrong after write");
endmodule

// ### serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
   input wire logic mclk_i,
   input wire logic rvalid_i,
   input wire logic [7:0] rdata_i,
   output logic wr_req_o = 1'b0,
   output logic rd_req_o = 1'b0,
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00
);
   // Released lines show the inverse so stale values are never mistaken for held ones.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_req_o = 1'b1;
      repeat (7) @(posedge mclk_i);
      #1;
      wr_req_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
      repeat (4) @(posedge mclk_i);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      #1;
      addr_o = a;
      rd_req_o = 1'b1;
      for (int n = 0; n < 10; n++) begin
         @(posedge mclk_i);
         if (rvalid_i === 1'b1) begin
            d = rdata_i;
            break;
         end
      end
      #1;
      rd_req_o = 1'b0;
      addr_o = ~a;
      repeat (4) @(posedge mclk_i);
   endtask
endmodule

// ### regulator_config_register_bank_tb_top.sv
`timescale 1ns/1ps
module regulator_config_register_bank_tb_top
   import regulator_config_pkg::*;
;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wr_req_i, rd_req_i, rvalid_o, fixed_frequency_enable_o, spread_spectrum_active_o;
   logic [7:0] addr_i, wdata_i, rdata_o, rd;
   logic [5:0] buck_one_voltage_code_o, buck_two_voltage_code_o, buck_three_voltage_code_o;
   logic [5:0] linreg_one_voltage_code_o, linreg_two_voltage_code_o;
   logic [5:0] linreg_three_voltage_code_o, linreg_four_voltage_code_o;
   logic [2:0] bandwidth_high_o, buck_undervolt_ten_pct_o;
   logic [1:0] buck_two_phase_offset_o, buck_three_phase_offset_o;
   logic [1:0] linreg_one_mode_o, linreg_two_mode_o;
   logic linreg_three_load_switch_o, linreg_four_load_switch_o, buck_one_standby_enable_o;
   logic linreg_three_slow_ramp_o, linreg_four_slow_ramp_o;
   logic [3:0] linreg_undervolt_ten_pct_o;
   logic [7:0] addrs [10];
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   regulator_config_register_bank dut_u (.mclk_i, .rst_n_i, .wr_req_i, .rd_req_i, .addr_i,
      .wdata_i, .rdata_o, .rvalid_o, .buck_one_voltage_code_o, .buck_two_voltage_code_o,
      .buck_three_voltage_code_o, .bandwidth_high_o, .buck_undervolt_ten_pct_o,
      .fixed_frequency_enable_o, .spread_spectrum_active_o, .buck_two_phase_offset_o,
      .buck_three_phase_offset_o, .linreg_one_voltage_code_o, .linreg_two_voltage_code_o,
      .linreg_three_voltage_code_o, .linreg_four_voltage_code_o, .linreg_one_mode_o,
      .linreg_two_mode_o, .linreg_three_load_switch_o, .linreg_four_load_switch_o,
      .linreg_three_slow_ramp_o, .linreg_four_slow_ramp_o, .linreg_undervolt_ten_pct_o,
      .buck_one_standby_enable_o);
   serial_host_model host_u (.mclk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o),
      .wr_req_o(wr_req_i), .rd_req_o(rd_req_i), .addr_o(addr_i), .wdata_o(wdata_i));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_u.read_reg(a, d);
      chk(n, e, d);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      addrs = '{buck_switching_mode_config_addr, ldo4_config_addr, ldo3_config_addr,
         ldo2_config_addr, ldo1_config_addr, buck3_config_addr, buck2_config_addr,
         buck1_config_addr, ldo_uv_threshold_config_addr, standby_enable_config_addr};
      repeat (6) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      for (int i = 0; i < 10; i++) rdchk("reset value", addrs[i], 8'h00);
      $display("test reset done");
      for (int i = 0; i < 10; i++) host_u.write_reg(addrs[i], addrs[i] ^ 8'hc4);
      for (int i = 0; i < 10; i++) rdchk("readback", addrs[i], addrs[i] ^ 8'hc4);
      chk("b1", (buck1_config_addr ^ 8'hc4) & 8'h3f, {2'h0, buck_one_voltage_code_o});
      chk("b2", (buck2_config_addr ^ 8'hc4) & 8'h3f, {2'h0, buck_two_voltage_code_o});
      chk("b3", (buck3_config_addr ^ 8'hc4) & 8'h3f, {2'h0, buck_three_voltage_code_o});
      chk("bw uv", 8'h3f, {2'h0, bandwidth_high_o, buck_undervolt_ten_pct_o});
      chk("l3 l4", 8'h0f, {4'h0, linreg_three_slow_ramp_o, linreg_three_load_switch_o,
         linreg_four_slow_ramp_o, linreg_four_load_switch_o});
      chk("luv", 8'h0b, {4'h0, linreg_undervolt_ten_pct_o});
      chk("stby", 8'h01, {7'h0, buck_one_standby_enable_o});
      chk("l2 code", 8'h02, {2'h0, linreg_two_voltage_code_o});
      chk("l3 code", 8'h01, {2'h0, linreg_three_voltage_code_o});
      $display("test fields done");
      host_u.read_reg(buck_switching_mode_config_addr, rd);
      host_u.write_reg(buck_switching_mode_config_addr, (rd & 8'h10) | 8'h2f);
      chk("ss off", 8'h00, {6'h0, spread_spectrum_active_o, fixed_frequency_enable_o});
      chk("ph off", 8'h00, {4'h0, buck_three_phase_offset_o, buck_two_phase_offset_o});
      host_u.write_reg(buck_switching_mode_config_addr, 8'h3b);
      chk("ss on", 8'h03, {6'h0, spread_spectrum_active_o, fixed_frequency_enable_o});
      chk("ph on", 8'h0b, {4'h0, buck_three_phase_offset_o, buck_two_phase_offset_o});
      $display("test switching done");
      for (int i = 0; i < 4; i++) begin
         host_u.write_reg(ldo1_config_addr, {i[1:0], 6'h15});
         chk("l1 mode", i[1] ? 8'h02 : 8'(i), {6'h0, linreg_one_mode_o});
         chk("l1 code", 8'h15, {2'h0, linreg_one_voltage_code_o});
      end
      host_u.write_reg(ldo2_config_addr, 8'h40);
      chk("l2 mode", 8'h01, {6'h0, linreg_two_mode_o});
      $display("test modes done");
      host_u.write_reg(8'h55, 8'h77);
      rdchk("unmapped", 8'h55, 8'h00);
      rdchk("kept", buck1_config_addr, buck1_config_addr ^ 8'hc4);
      $display("test unmapped done");
      @(posedge mclk_i);
      #1 rst_n_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      chk("rst code", 8'h00, {2'h0, buck_one_voltage_code_o});
      rdchk("rst reg", buck1_config_addr, 8'h00);
      $display("test second reset done");
      end_of_test();
   end
endmodule
bind regulator_config_register_bank regulator_config_asserts chk_u (.mclk_i, .rst_n_i, .wr_req_i,
   .rd_req_i, .addr_i, .wdata_i, .rvalid_o, .buck_one_voltage_code_o, .bandwidth_high_o,
   .buck_undervolt_ten_pct_o, .fixed_frequency_enable_o, .spread_spectrum_active_o,
   .buck_two_phase_offset_o, .buck_three_phase_offset_o, .linreg_one_mode_o,
   .linreg_four_voltage_code_o, .linreg_four_load_switch_o, .linreg_four_slow_ramp_o,
   .linreg_undervolt_ten_pct_o);
